// ==== core/sram_ctrl_defines.vh ====
`ifndef SRAM_CTRL_DEFINES_VH
`define SRAM_CTRL_DEFINES_VH

`define CLK_PERIOD_NS 40
`define ADDR_W 11
`define DATA_W 8
`define T_ACCESS_NS 70
`define T_GATE_RELEASE_NS 30
`define T_SELECT_RELEASE_NS 35
`define T_WRITE_RELEASE_NS 30
`define T_WRITE_PULSE_NS 40
`define T_ADDR_TO_END_NS 65
`define T_SELECT_TO_END_NS 60
`define T_DATA_SETUP_NS 30
`define T_DATA_HOLD_NS 5
`define T_CYCLE_NS 70
`define T_STANDBY_NS 40
// Flip-flop stages on the returning data
`define SYNC_STAGES 2
// Least times round up to whole cycles, never below one
`define CYC_UP(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CNT_W 4

`endif

// ==== core/phase_timer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_defines.vh"
// ----------------------------------------
// Down counter that pulses done when it runs out
// ----------------------------------------
module phase_timer (
    // Clock and reset
    input wire mclk_i,
    input wire resetn_i,
    // Control
    input wire load_i,
    input wire [`CNT_W-1:0] count_i,
    output reg done_o
);
    reg [`CNT_W-1:0] cnt_q;

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= {`CNT_W{1'b0}};
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_q <= count_i;
            done_o <= 1'b0;
        end else if (cnt_q != {`CNT_W{1'b0}}) begin
            cnt_q <= cnt_q - {{(`CNT_W-1){1'b0}}, 1'b1};
            done_o <= (cnt_q == {{(`CNT_W-1){1'b0}}, 1'b1});
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== core/sram_host_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_defines.vh"
module sram_host_ctrl (
    // Clock and reset
    input wire mclk_i,
    input wire resetn_i,
    // User request
    input wire req_i,
    input wire req_write_i,
    input wire [`ADDR_W-1:0] req_addr_i,
    input wire [`DATA_W-1:0] req_wdata_i,
    output reg req_ready_o,
    output reg rdata_valid_o,
    output reg [`DATA_W-1:0] rdata_o,
    // Memory pins
    output reg [`ADDR_W-1:0] word_address_o,
    output reg select_n_o,
    output reg gate_n_o,
    output reg write_n_o,
    input wire [`DATA_W-1:0] shared_data_port_i,
    output reg [`DATA_W-1:0] shared_data_port_o,
    output reg shared_data_port_oe_n_o
);
    // ----------------------------------------
    // Cycle arithmetic
    // ----------------------------------------
    // Larger of two phase lengths; the slower limit always wins
    function [`CNT_W-1:0] max_cyc;
        input [`CNT_W-1:0] a;
        input [`CNT_W-1:0] b;
        begin
            max_cyc = (a > b) ? a : b;
        end
    endfunction

    // ----------------------------------------
    // Phase lengths in clock cycles
    // ----------------------------------------
    // Whole-cycle forms first, then cut to the timer width on purpose
    localparam integer ACCESS_I = `CYC_UP(`T_ACCESS_NS);
    localparam integer SEL_REL_I = `CYC_UP(`T_SELECT_RELEASE_NS);
    localparam integer GATE_REL_I = `CYC_UP(`T_GATE_RELEASE_NS);
    localparam integer STROBE_I = `CYC_UP(`T_WRITE_PULSE_NS);
    localparam integer ADDR_END_I = `CYC_UP(`T_ADDR_TO_END_NS);
    localparam integer SEL_END_I = `CYC_UP(`T_SELECT_TO_END_NS);
    localparam integer SETUP_I = `CYC_UP(`T_DATA_SETUP_NS);
    localparam integer TURN_I = `CYC_UP(`T_WRITE_RELEASE_NS);
    localparam integer HOLD_I = `CYC_UP(`T_DATA_HOLD_NS);
    localparam integer CYCLE_I = `CYC_UP(`T_CYCLE_NS);
    localparam integer SYNC_I = `SYNC_STAGES;
    localparam [`CNT_W-1:0] ACCESS_CYC = ACCESS_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] SEL_REL_CYC = SEL_REL_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] GATE_REL_CYC = GATE_REL_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] STROBE_CYC = STROBE_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] ADDR_END_CYC = ADDR_END_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] SEL_END_CYC = SEL_END_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] SETUP_CYC = SETUP_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] TURN_CYC = TURN_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] HOLD_CYC = HOLD_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] CYCLE_CYC = CYCLE_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] SYNC_CYC = SYNC_I[`CNT_W-1:0];
    // Port turnaround waits the slower of the two release times
    localparam [`CNT_W-1:0] RELEASE_CYC = max_cyc(SEL_REL_CYC, GATE_REL_CYC);
    // Access time plus the input synchroniser stages
    localparam [`CNT_W-1:0] RD_WAIT_CYC = ACCESS_CYC + SYNC_CYC;
    localparam [`CNT_W-1:0] RD_GAP_CYC = CYCLE_CYC - RELEASE_CYC;
    // Strobe covers pulse, data setup, address and select to end
    localparam [`CNT_W-1:0] WR_CYC = max_cyc(max_cyc(STROBE_CYC, ADDR_END_CYC), max_cyc(SEL_END_CYC, SETUP_CYC));

    // ----------------------------------------
    // State codes
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RD = 3'h1;
    localparam [2:0] ST_RD_END = 3'h2;
    localparam [2:0] ST_WR_TURN = 3'h3;
    localparam [2:0] ST_WR = 3'h4;
    localparam [2:0] ST_WR_HOLD = 3'h5;
    localparam [2:0] ST_GAP = 3'h6;

    reg [2:0] state_q;
    reg load_q;
    reg [`CNT_W-1:0] count_q;
    reg [`DATA_W-1:0] din_meta_q;
    reg [`DATA_W-1:0] din_sync_q;
    wire done;
    // Read ends on the access timer, in the read state only
    wire rd_capture;
    assign rd_capture = (state_q == ST_RD) && done;

    phase_timer u_timer (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .load_i(load_q),
        .count_i(count_q),
        .done_o(done)
    );

    // ----------------------------------------
    // Read data synchroniser
    // ----------------------------------------
    // Two stages settle an async port; the access time is counted by the read timer
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            din_meta_q <= {`DATA_W{1'b0}};
            din_sync_q <= {`DATA_W{1'b0}};
        end else begin
            din_meta_q <= shared_data_port_i;
            din_sync_q <= din_meta_q;
        end
    end

    // ----------------------------------------
    // Read data return
    // ----------------------------------------
    // Byte holds until the next read, so a slow user may take it late
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_valid_o <= 1'b0;
            rdata_o <= {`DATA_W{1'b0}};
        end else begin
            rdata_valid_o <= rd_capture;
            if (rd_capture) begin
                rdata_o <= din_sync_q;
            end
        end
    end

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            load_q <= 1'b0;
            count_q <= {`CNT_W{1'b0}};
            req_ready_o <= 1'b1;
            word_address_o <= {`ADDR_W{1'b0}};
            select_n_o <= 1'b1;
            gate_n_o <= 1'b1;
            write_n_o <= 1'b1;
            shared_data_port_o <= {`DATA_W{1'b0}};
            shared_data_port_oe_n_o <= 1'b1;
        end else begin
            load_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        // Address and select change together, never select first
                        word_address_o <= req_addr_i;
                        select_n_o <= 1'b0;
                        load_q <= 1'b1;
                        if (req_write_i) begin
                            shared_data_port_o <= req_wdata_i;
                            count_q <= TURN_CYC;
                            state_q <= ST_WR_TURN;
                        end else begin
                            gate_n_o <= 1'b0;
                            // Two extra cycles for the input synchroniser
                            count_q <= RD_WAIT_CYC;
                            state_q <= ST_RD;
                        end
                    end
                end
                ST_RD: begin
                    if (done) begin
                        select_n_o <= 1'b1;
                        gate_n_o <= 1'b1;
                        load_q <= 1'b1;
                        count_q <= RELEASE_CYC;
                        state_q <= ST_RD_END;
                    end
                end
                ST_RD_END: begin
                    if (done) begin
                        load_q <= 1'b1;
                        count_q <= RD_GAP_CYC;
                        state_q <= ST_GAP;
                    end
                end
                ST_WR_TURN: begin
                    if (done) begin
                        // Memory is quiet; drive data and open the strobe on the same edge
                        shared_data_port_oe_n_o <= 1'b0;
                        write_n_o <= 1'b0;
                        load_q <= 1'b1;
                        count_q <= WR_CYC;
                        state_q <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (done) begin
                        // Strobe rises before select, so it ends the write
                        write_n_o <= 1'b1;
                        load_q <= 1'b1;
                        count_q <= HOLD_CYC;
                        state_q <= ST_WR_HOLD;
                    end
                end
                ST_WR_HOLD: begin
                    if (done) begin
                        shared_data_port_oe_n_o <= 1'b1;
                        select_n_o <= 1'b1;
                        load_q <= 1'b1;
                        count_q <= HOLD_CYC;
                        state_q <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (done) begin
                        req_ready_o <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    req_ready_o <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== tb/sram_host_ctrl_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_defines.vh"
module sram_host_ctrl_checker (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [`ADDR_W-1:0] word_address_o,
    input wire logic select_n_o,
    input wire logic gate_n_o,
    input wire logic write_n_o,
    input wire logic [`DATA_W-1:0] shared_data_port_o,
    input wire logic shared_data_port_oe_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_end; $rose(write_n_o); endsequence
    property p_wlen; $fell(write_n_o) |=> !write_n_o; endproperty
    a_wlen: assert property (p_wlen) else $error("strobe short");
    property p_adr; s_end |-> $past(word_address_o, 2) == word_address_o; endproperty
    a_adr: assert property (p_adr) else $error("address moved");
    property p_sel; s_end |-> !$past(select_n_o, 2); endproperty
    a_sel: assert property (p_sel) else $error("select late");
    property p_dat; s_end |-> !shared_data_port_oe_n_o && $stable(shared_data_port_o); endproperty
    a_dat: assert property (p_dat) else $error("data moved");
    property p_wr; !write_n_o |-> !select_n_o && !shared_data_port_oe_n_o && gate_n_o; endproperty
    a_wr: assert property (p_wr) else $error("bad write");
    property p_rd; !gate_n_o |-> !select_n_o && write_n_o && shared_data_port_oe_n_o; endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_hold; !select_n_o && !$past(select_n_o) |-> $stable(word_address_o); endproperty
    a_hold: assert property (p_hold) else $error("address slipped");
    property p_gap; $fell(select_n_o) |-> $past(select_n_o, 2); endproperty
    a_gap: assert property (p_gap) else $error("cycles too close");
endmodule
bind sram_host_ctrl sram_host_ctrl_checker sram_host_ctrl_checker_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .word_address_o(word_address_o), .select_n_o(select_n_o), .gate_n_o(gate_n_o), .write_n_o(write_n_o),
    .shared_data_port_o(shared_data_port_o), .shared_data_port_oe_n_o(shared_data_port_oe_n_o));
`default_nettype wire

// ==== tb/sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_defines.vh"
module sram_model (
    input wire logic [`ADDR_W-1:0] word_address_i,
    input wire logic select_n_i,
    input wire logic gate_n_i,
    input wire logic write_n_i,
    input wire logic host_oe_n_i,
    input wire logic [`DATA_W-1:0] host_data_i,
    output logic [`DATA_W-1:0] bus_o,
    output logic clash_o
);
    logic [`DATA_W-1:0] mem [0:2047];
    logic [`DATA_W-1:0] rd = '0;
    logic [`DATA_W-1:0] last = '0;
    logic drive = 1'b0;
    logic standby = 1'b1;
    wire logic rd_on = !select_n_i && !gate_n_i && write_n_i;
    wire logic wr_on = !select_n_i && !write_n_i;
    initial clash_o = 1'b0;
    // Junk between hold and access time, so early sampling fails
    always @(word_address_i or negedge select_n_i) begin
        rd <= #5 ~rd;
        rd <= #70 mem[word_address_i];
    end
    always @(rd_on) begin
        if (rd_on) drive <= #5 1'b1;
        else drive <= #30 1'b0;
    end
    always @(select_n_i) standby <= #(select_n_i ? 40 : 0) select_n_i;
    // Released lines show the inverse of the last driven byte
    assign bus_o = !host_oe_n_i ? host_data_i : (drive ? rd : ~last);
    always @(bus_o) if (!host_oe_n_i || drive) last = bus_o;
    always @(negedge wr_on) mem[word_address_i] <= bus_o;
    // Driving while asleep or against the host both count as a clash
    always @(posedge drive) if (!host_oe_n_i || standby) clash_o = 1'b1;
    always @(negedge host_oe_n_i) if (drive) clash_o = 1'b1;
endmodule
`default_nettype wire

// ==== tb/sram_host_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_defines.vh"
module sram_host_ctrl_tb;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [`ADDR_W-1:0] req_addr_i = '0;
    logic [`DATA_W-1:0] req_wdata_i = '0;
    wire logic ready, valid, sel_n, gate_n, wr_n, oe_n, clash;
    wire logic [`DATA_W-1:0] rdata, from_mem, to_mem;
    wire logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] shadow [0:2047];
    logic [31:0] r;
    integer err_count = 0;
    integer n_tests = 0;
    integer seed = 31280;
    integer i;
    always #20 mclk_i = ~mclk_i;
    sram_host_ctrl sram_host_ctrl_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(ready), .rdata_valid_o(valid), .rdata_o(rdata), .word_address_o(addr),
        .select_n_o(sel_n), .gate_n_o(gate_n), .write_n_o(wr_n), .shared_data_port_i(from_mem),
        .shared_data_port_o(to_mem), .shared_data_port_oe_n_o(oe_n));
    sram_model sram_model_i (.word_address_i(addr), .select_n_i(sel_n), .gate_n_i(gate_n),
        .write_n_i(wr_n), .host_oe_n_i(oe_n), .host_data_i(to_mem), .bus_o(from_mem), .clash_o(clash));
    function automatic logic [`DATA_W-1:0] expect_byte(input logic [`ADDR_W-1:0] a);
        return shadow[a];
    endfunction
    task automatic chk(input logic [`DATA_W-1:0] seen, input logic [`DATA_W-1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic op(input logic wr, input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
        integer k;
        for (k = 0; k < 40 && ready !== 1'b1; k++) @(negedge mclk_i);
        if (k == 40) begin err_count++; conclude(); end
        req_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge mclk_i);
        req_i = 1'b0;
        req_wdata_i = ~d;
        if (wr) shadow[a] = d;
        for (k = 0; k < 40 && !wr && valid !== 1'b1; k++) @(negedge mclk_i);
        if (k == 40) begin err_count++; conclude(); end
        if (!wr) chk(rdata, expect_byte(a));
    endtask
    initial begin
        repeat (2) @(negedge mclk_i);
        resetn_i = 1'b1;
        op(1'b1, 11'h000, 8'h5a);
        op(1'b1, 11'h7ff, 8'ha5);
        // Request while busy must be ignored
        req_i = 1'b1;
        req_addr_i = 11'h000;
        @(negedge mclk_i);
        req_i = 1'b0;
        op(1'b0, 11'h000, 8'h00);
        op(1'b0, 11'h7ff, 8'h00);
        for (i = 0; i < 64; i++) begin
            r = $random(seed);
            op(1'b1, r[10:0], r[18:11]);
            op(1'b0, r[10:0], 8'h00);
        end
        chk({{(`DATA_W-1){1'b0}}, clash}, {`DATA_W{1'b0}});
        conclude();
    end
endmodule
`default_nettype wire
